// file: core/dbc_core.sv
/*
 * Burst access core of an eight-bank double-rate DRAM, device side.
 * Command, address and data logic run on the controller's reference
 * clock; status and self refresh pacing run on the core clock.
 * Assumes the controller drives pins from its own reference clock.
 */
`timescale 1ns/10ps
`default_nettype none

module dbc_core (
    input  wire logic                       CLOCK_IN,         // Core clock
    input  wire logic                       RST_IN,           // Sync reset
    input  wire logic                       REF_CLK_TRUE_IN,  // Link clock
    input  wire logic                       CKE_IN,           // Clock enable
    input  wire logic                       CS_N_IN,          // Select
    input  wire logic                       RAS_N_IN,         // Row strobe
    input  wire logic                       CAS_N_IN,         // Column strobe
    input  wire logic                       WE_N_IN,          // Write enable
    input  wire logic [2:0]                 BA_IN,            // Bank
    input  wire logic [dbc_pkg::ROW_W-1:0]  A_IN,             // Address
    input  wire logic [dbc_pkg::N_W-1:0]    DQ_IN,            // Data in
    input  wire logic                       DQS_IN,           // Strobe in
    output logic      [dbc_pkg::N_W-1:0]    DQ_OUT,           // Data out
    output logic                            DQ_OE_OUT,        // Data drive
    output logic                            DQS_OUT,          // Strobe out
    output logic                            DQS_N_OUT,        // Strobe comp
    output logic                            DQS_OE_OUT,       // Strobe drive
    output logic                            SELF_REFRESH_OUT, // In refresh
    output logic                            POWER_DOWN_OUT,   // Powered down
    output logic      [7:0]                 BANKS_OPEN_OUT,   // Open banks
    output logic      [dbc_pkg::ROW_W-1:0]  REFRESH_ROW_OUT   // Refresh row
);
    localparam int RD_DQ = int'(dbc_pkg::RD_LAT) + 2;

    // ========================================================
    // State types
    typedef struct packed {
        dbc_pkg::dbc_lstate_t                        st;
        logic [3:0]                                  cnt;
        logic [3:0]                                  beat;
        logic                                        cke_q;
        logic [2:0]                                  bank;
        logic [2:0]                                  slot;
        logic                                        chop;
        logic                                        ap;
        logic [dbc_pkg::MEM_AW-1:0]                  rad;
        logic [7:0]                                  open;
        logic [dbc_pkg::NBANK-1:0][dbc_pkg::ROW_W-1:0] row;
        logic [dbc_pkg::WORD_W-1:0]                  wbuf;
        logic [7:0]                                  wbe;
        logic                                        we;
        logic                                        dqs_q;
        logic [dbc_pkg::N_W-1:0]                     dq;
        logic                                        dq_oe;
        logic                                        dqs;
        logic                                        dqs_oe;
    } dbc_link_t;

    typedef struct packed {
        logic                      sr1;
        logic                      sr2;
        logic                      pd1;
        logic                      pd2;
        logic [7:0]                bo1;
        logic [7:0]                bo2;
        logic [10:0]               timer;
        logic [dbc_pkg::ROW_W-1:0] rrow;
    } dbc_core_t;

    dbc_link_t                   l_r;
    dbc_link_t                   l_nxt;
    dbc_core_t                   c_r;
    dbc_core_t                   c_nxt;
    logic                        lrst_s1_r;
    logic                        lrst_r;
    dbc_pkg::dbc_cmd_t           cmd;
    logic [dbc_pkg::WORD_W-1:0]  rd_word;
    logic [3:0]                  last;
    logic [2:0]                  pos;
    logic                        rw_go;

    // ========================================================
    // Array
    dbc_mem u_mem (
        .clk_in    (REF_CLK_TRUE_IN),
        .we_in     (l_r.we),
        .wbe_in    (l_r.wbe),
        .addr_in   (l_r.rad),
        .wdata_in  (l_r.wbuf),
        .rdata_out (rd_word)
    );

    // ========================================================
    // Link reset
    always_ff @(posedge REF_CLK_TRUE_IN) begin
        lrst_s1_r <= RST_IN;
        lrst_r    <= lrst_s1_r;
    end

    // ========================================================
    // Command decode
    // decode on rising edge
    always_comb begin
        cmd = dbc_pkg::CMD_NOP;
        if (!CS_N_IN && CKE_IN) begin
            case ({RAS_N_IN, CAS_N_IN, WE_N_IN})
                3'h3:    cmd = dbc_pkg::CMD_ACT;
                3'h5:    cmd = dbc_pkg::CMD_RD;
                3'h4:    cmd = dbc_pkg::CMD_WR;
                3'h2:    cmd = dbc_pkg::CMD_PRE;
                3'h1:    cmd = dbc_pkg::CMD_REF;
                default: cmd = dbc_pkg::CMD_NOP;
            endcase
        end
    end

    assign last  = l_r.chop ? dbc_pkg::BEATS_CHOP : dbc_pkg::BEATS_FULL;
    assign pos   = l_r.slot + l_r.beat[2:0];
    assign rw_go = (l_r.st == dbc_pkg::LS_IDLE) && l_r.open[BA_IN] &&
                   (cmd == dbc_pkg::CMD_RD || cmd == dbc_pkg::CMD_WR);

    // ========================================================
    // Link next state
    always_comb begin
        l_nxt        = l_r;
        l_nxt.cke_q  = CKE_IN;
        l_nxt.dqs_q  = DQS_IN;
        l_nxt.we     = 1'b0;
        l_nxt.dq     = 4'h0;
        l_nxt.dq_oe  = 1'b0;
        l_nxt.dqs    = 1'b0;
        l_nxt.dqs_oe = 1'b0;

        // bank commands in any awake state
        if (l_r.st != dbc_pkg::LS_PDN && l_r.st != dbc_pkg::LS_SREF) begin
            if (cmd == dbc_pkg::CMD_ACT && !l_r.open[BA_IN]) begin
                l_nxt.open[BA_IN] = 1'b1;
                l_nxt.row[BA_IN]  = A_IN;
            end
            if (cmd == dbc_pkg::CMD_PRE) begin
                if (A_IN[dbc_pkg::AP_BIT]) begin
                    l_nxt.open = 8'h00;
                end else begin
                    l_nxt.open[BA_IN] = 1'b0;
                end
            end
        end

        unique case (l_r.st)
            dbc_pkg::LS_IDLE: begin
                if (rw_go) begin
                    l_nxt.bank = BA_IN;
                    l_nxt.slot = A_IN[2:0];
                    l_nxt.rad  = {BA_IN, l_r.row[BA_IN][1:0], A_IN[4:3]};
                    l_nxt.chop = !A_IN[dbc_pkg::BC_BIT];
                    l_nxt.ap   = A_IN[dbc_pkg::AP_BIT];
                    l_nxt.wbe  = 8'h00;
                    if (cmd == dbc_pkg::CMD_RD) begin
                        l_nxt.cnt = dbc_pkg::RD_LAT - 4'h1;
                        l_nxt.st  = dbc_pkg::LS_RWAIT;
                    end else begin
                        l_nxt.cnt = dbc_pkg::WR_LAT - 4'h1;
                        l_nxt.st  = dbc_pkg::LS_WWAIT;
                    end
                end else if (l_r.cke_q && !CKE_IN) begin
                    if (!CS_N_IN && {RAS_N_IN, CAS_N_IN, WE_N_IN} == 3'h1 &&
                        l_r.open == 8'h00) begin
                        l_nxt.st = dbc_pkg::LS_SREF;
                    end else if (CS_N_IN || {RAS_N_IN, CAS_N_IN, WE_N_IN} == 3'h7) begin
                        l_nxt.st = dbc_pkg::LS_PDN;
                    end
                end
            end
            dbc_pkg::LS_RWAIT: begin
                if (l_r.cnt == 4'h0) begin
                    l_nxt.st     = dbc_pkg::LS_RPRE;
                    l_nxt.dqs_oe = 1'b1;
                end else begin
                    l_nxt.cnt = l_r.cnt - 4'h1;
                end
            end
            dbc_pkg::LS_RPRE: begin
                l_nxt.st     = dbc_pkg::LS_RBURST;
                l_nxt.beat   = 4'h1;
                l_nxt.dq     = rd_word[{l_r.slot, 2'b00} +: dbc_pkg::N_W];
                l_nxt.dq_oe  = 1'b1;
                l_nxt.dqs    = 1'b1;
                l_nxt.dqs_oe = 1'b1;
            end
            dbc_pkg::LS_RBURST: begin
                if (l_r.beat == last) begin
                    l_nxt.st = dbc_pkg::LS_IDLE;
                    if (l_r.ap) begin
                        l_nxt.open[l_r.bank] = 1'b0;
                    end
                end else begin
                    l_nxt.dq     = rd_word[{pos, 2'b00} +: dbc_pkg::N_W];
                    l_nxt.dq_oe  = 1'b1;
                    l_nxt.dqs    = !l_r.beat[0];
                    l_nxt.dqs_oe = 1'b1;
                    l_nxt.beat   = l_r.beat + 4'h1;
                end
            end
            dbc_pkg::LS_WWAIT: begin
                if (l_r.cnt == 4'h0) begin
                    l_nxt.st = dbc_pkg::LS_WPRE;
                end else begin
                    l_nxt.cnt = l_r.cnt - 4'h1;
                end
            end
            dbc_pkg::LS_WPRE: begin
                if (!DQS_IN) begin
                    l_nxt.st   = dbc_pkg::LS_WBURST;
                    l_nxt.beat = 4'h0;
                end
            end
            dbc_pkg::LS_WBURST: begin
                if (DQS_IN != l_r.dqs_q) begin
                    l_nxt.wbuf[{pos, 2'b00} +: dbc_pkg::N_W] = DQ_IN;
                    l_nxt.wbe[pos] = 1'b1;
                    l_nxt.beat     = l_r.beat + 4'h1;
                    if (l_r.beat == last - 4'h1) begin
                        l_nxt.we = 1'b1;
                        l_nxt.st = dbc_pkg::LS_IDLE;
                        if (l_r.ap) begin
                            l_nxt.open[l_r.bank] = 1'b0;
                        end
                    end
                end
            end
            dbc_pkg::LS_PDN, dbc_pkg::LS_SREF: begin
                if (CKE_IN) begin
                    l_nxt.st = dbc_pkg::LS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK_TRUE_IN) begin
        if (lrst_r) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    // ========================================================
    // Core side: status sync and self refresh pacing
    always_comb begin
        c_nxt     = c_r;
        c_nxt.sr1 = (l_r.st == dbc_pkg::LS_SREF);
        c_nxt.sr2 = c_r.sr1;
        c_nxt.pd1 = (l_r.st == dbc_pkg::LS_PDN);
        c_nxt.pd2 = c_r.pd1;
        c_nxt.bo1 = l_r.open;
        c_nxt.bo2 = c_r.bo1;
        if (c_r.sr2) begin
            if (c_r.timer == dbc_pkg::TIMER_RST) begin
                c_nxt.timer = dbc_pkg::SREF_CYC - 11'h001;
                c_nxt.rrow  = c_r.rrow + 14'h0001;
            end else begin
                c_nxt.timer = c_r.timer - 11'h001;
            end
        end else begin
            c_nxt.timer = dbc_pkg::TIMER_RST;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            c_r <= '0;
        end else begin
            c_r <= c_nxt;
        end
    end

    // ========================================================
    // Outputs
    assign DQ_OUT           = l_r.dq;
    assign DQ_OE_OUT        = l_r.dq_oe;
    assign DQS_OUT          = l_r.dqs;
    assign DQS_N_OUT        = !l_r.dqs;
    assign DQS_OE_OUT       = l_r.dqs_oe;
    assign SELF_REFRESH_OUT = c_r.sr2;
    assign POWER_DOWN_OUT   = c_r.pd2;
    assign BANKS_OPEN_OUT   = c_r.bo2;
    assign REFRESH_ROW_OUT  = c_r.rrow;

    // ========================================================
    // Checks
    AST_READ_LAT: assert property (
        @(posedge REF_CLK_TRUE_IN) disable iff (lrst_r)
        rw_go && cmd == dbc_pkg::CMD_RD |-> ##RD_DQ DQ_OE_OUT)
        else $error("read data late or early");
    AST_PREAMBLE: assert property (
        @(posedge REF_CLK_TRUE_IN) disable iff (lrst_r)
        $rose(DQ_OE_OUT) |-> $past(DQS_OE_OUT) && !$past(DQS_OUT) && DQS_OUT)
        else $error("read preamble missing");
    AST_MIN_BEATS: assert property (
        @(posedge REF_CLK_TRUE_IN) disable iff (lrst_r)
        $rose(DQ_OE_OUT) |-> DQ_OE_OUT[*4])
        else $error("read burst too short");
    AST_EDGE_ALIGN: assert property (
        @(posedge REF_CLK_TRUE_IN) disable iff (lrst_r)
        DQ_OE_OUT && $past(DQ_OE_OUT) |-> DQS_OUT != $past(DQS_OUT))
        else $error("strobe did not toggle with data");
    AST_AP_CLOSE: assert property (
        @(posedge REF_CLK_TRUE_IN) disable iff (lrst_r)
        l_r.st == dbc_pkg::LS_RBURST && l_r.beat == last && l_r.ap
        |=> !l_r.open[$past(l_r.bank)])
        else $error("auto precharge left row open");
    AST_ACT_OPEN: assert property (
        @(posedge REF_CLK_TRUE_IN) disable iff (lrst_r)
        cmd == dbc_pkg::CMD_ACT && !l_r.open[BA_IN] &&
        l_r.st != dbc_pkg::LS_SREF && l_r.st != dbc_pkg::LS_PDN
        |=> l_r.open[$past(BA_IN)] && l_r.row[$past(BA_IN)] == $past(A_IN))
        else $error("activate did not open row");
    AST_WRITE_FIRST: assert property (
        @(posedge REF_CLK_TRUE_IN) disable iff (lrst_r)
        l_r.st == dbc_pkg::LS_WBURST && l_r.beat == 4'h0 && DQS_IN && !l_r.dqs_q
        |=> l_r.wbe[$past(l_r.slot)] && l_r.beat == 4'h1)
        else $error("first write beat not captured");
    AST_WRITE_COMMIT: assert property (
        @(posedge REF_CLK_TRUE_IN) disable iff (lrst_r)
        l_r.we |-> l_r.st == dbc_pkg::LS_IDLE && l_r.wbe != 8'h00)
        else $error("array write without beats");
    AST_SREF_ROW: assert property (
        @(posedge CLOCK_IN) disable iff (RST_IN)
        c_r.sr2 && c_r.timer == dbc_pkg::TIMER_RST
        |=> REFRESH_ROW_OUT == $past(REFRESH_ROW_OUT) + 14'h0001)
        else $error("refresh row did not advance");

endmodule // dbc_core

`default_nettype wire

// file: core/dbc_mem.sv
/*
 * Array store: one eight-beat word per entry, nibble write enables,
 * registered read data.
 * Assumes address and enables come from flops of the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module dbc_mem (
    input  wire logic                       clk_in,    // Array clock
    input  wire logic                       we_in,     // Write strobe
    input  wire logic [7:0]                 wbe_in,    // Beat enables
    input  wire logic [dbc_pkg::MEM_AW-1:0] addr_in,   // Entry index
    input  wire logic [dbc_pkg::WORD_W-1:0] wdata_in,  // Write word
    output logic      [dbc_pkg::WORD_W-1:0] rdata_out  // Read word
);

    localparam int DEPTH = 1 << dbc_pkg::MEM_AW;

    typedef struct packed {
        logic [DEPTH-1:0][dbc_pkg::WORD_W-1:0] mem;
        logic [dbc_pkg::WORD_W-1:0]            rd;
    } dbc_mem_st_t;

    dbc_mem_st_t               s_r;
    dbc_mem_st_t               s_nxt;
    logic [dbc_pkg::WORD_W-1:0] merged;

    // ========================================================
    // Per-beat merge
    // ========================================================
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_beat
            assign merged[g*dbc_pkg::N_W +: dbc_pkg::N_W] = wbe_in[g] ?
                wdata_in[g*dbc_pkg::N_W +: dbc_pkg::N_W] :
                s_r.mem[addr_in][g*dbc_pkg::N_W +: dbc_pkg::N_W];
        end
    endgenerate

    always_comb begin
        s_nxt    = s_r;
        s_nxt.rd = s_r.mem[addr_in];
        if (we_in) begin
            s_nxt.mem[addr_in] = merged;
        end
    end

    always_ff @(posedge clk_in) begin
        s_r <= s_nxt;
    end

    assign rdata_out = s_r.rd;

endmodule // dbc_mem

`default_nettype wire

// file: core/dbc_pkg.sv
/*
 * Constants and shared types for the burst access core.
 * Assumes a four-bit data lane and eight banks, with command and data
 * timed by the controller's reference clock.
 */
`default_nettype none

package dbc_pkg;

    // ========================================================
    // Data path geometry
    // ========================================================
    localparam int        N_W        = 4;
    localparam int        WORD_W     = 8 * N_W;
    localparam int        NBANK      = 8;
    localparam int        BANK_W     = 3;
    localparam int        ROW_W      = 14;
    localparam int        ROW_TOP    = 13;
    localparam int        MEM_AW     = 7;
    localparam int        AP_BIT     = 10;
    localparam int        BC_BIT     = 12;
    localparam logic [3:0] BEATS_FULL = 4'h8;
    localparam logic [3:0] BEATS_CHOP = 4'h4;

    // ========================================================
    // Latencies in reference clock cycles
    // ========================================================
    localparam logic [3:0] RD_LAT = 4'h5;
    localparam logic [3:0] WR_LAT = 4'h4;

    // ========================================================
    // Self refresh timing on the core clock
    // ========================================================
    localparam int          CLK_NS    = 5;
    localparam int          SREF_NS   = 7800;
    localparam logic [10:0] SREF_CYC  = 11'(SREF_NS / CLK_NS);
    localparam logic [10:0] TIMER_RST = 11'h000;

    // ========================================================
    // Commands and link states
    // ========================================================
    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF
    } dbc_cmd_t;

    typedef enum logic [3:0] {
        LS_IDLE, LS_RWAIT, LS_RPRE, LS_RBURST,
        LS_WWAIT, LS_WPRE, LS_WBURST, LS_PDN, LS_SREF
    } dbc_lstate_t;

endpackage

`default_nettype wire

// file: test/dbc_ctl_model.sv
/*
 * Controller model: commands, write bursts and read capture on the link clock.
 * Assumes the bench resolves the shared data and strobe wires.
 */
`timescale 1ns/10ps
`default_nettype none

module dbc_ctl_model (
    input  wire logic        lclk_in,   // Link clock
    input  wire logic [3:0]  dq_in,     // Data wire
    input  wire logic        dqs_in,    // Strobe wire
    input  wire logic        dqs_n_in,  // Strobe complement from device
    input  wire logic        dq_oe_in,  // Device drives data
    input  wire logic        dqs_oe_in, // Device drives strobe
    output logic             cke_out,   // Clock enable
    output logic             cs_n_out,  // Select
    output logic [2:0]       cmd_out,   // Row, column, write strobes
    output logic [2:0]       ba_out,    // Bank
    output logic [13:0]      a_out,     // Address
    output logic [3:0]       dq_out,    // Write data
    output logic             dqs_out    // Write strobe, rests low
);
    initial begin
        {cke_out, cs_n_out, cmd_out, ba_out, a_out} = {2'h3, 3'h7, 3'h0, 14'h0};
        dq_out = 4'h0;
        dqs_out = 1'b0;
    end

    task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [13:0] ad, input logic ck);
        @(posedge lclk_in);
        cs_n_out <= 1'b0;
        cmd_out <= c;
        ba_out <= b;
        a_out <= ad;
        cke_out <= ck;
        @(posedge lclk_in);
        cs_n_out <= 1'b1;
        cmd_out <= ~c;
        a_out <= ~ad;
    endtask

    task automatic wr(input logic [31:0] w, input int n);
        repeat (5) @(posedge lclk_in);
        for (int i = 0; i < n; i++) begin
            dq_out <= w[4*i+:4];
            dqs_out <= ~i[0];
            @(posedge lclk_in);
        end
        dq_out <= ~dq_out;
        repeat (2) @(posedge lclk_in);
    endtask

    task automatic rd(input int n, output logic [31:0] w, output logic ok);
        w = 32'h0;
        repeat (5) @(posedge lclk_in);
        #1;
        ok = dqs_oe_in & ~dqs_in & ~dq_oe_in;
        for (int i = 0; i < n; i++) begin
            @(posedge lclk_in);
            #1;
            ok &= dq_oe_in & (dqs_in == ~i[0]) & (dqs_n_in == i[0]);
            w[4*i+:4] = dq_in;
        end
        @(posedge lclk_in);
        #1;
        ok &= ~dq_oe_in;
    endtask
endmodule // dbc_ctl_model

`default_nettype wire

// file: test/tb_top.sv
/*
 * Self-checking bench for the burst access core.
 * Assumes the controller model drives every link input.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    localparam logic [2:0] ACT = 3'h3;
    localparam logic [2:0] RD  = 3'h5;
    localparam logic [2:0] WR  = 3'h4;
    localparam logic [2:0] REF = 3'h1;
    localparam logic [2:0] PRE = 3'h2;
    localparam logic [2:0] NOP = 3'h7;
    logic        clk, lclk, rst, cke, cs_n, ok;
    logic [2:0]  cmd, ba;
    logic [13:0] a, rrow;
    logic [3:0]  m_dq, d_dq;
    logic        m_dqs, d_dqs, dqs_n, dq_oe, dqs_oe, sref, pdn;
    logic [7:0]  banks;
    wire  [3:0]  dq_w = dq_oe ? d_dq : m_dq;
    wire         dqs_w = dqs_oe ? d_dqs : m_dqs;
    int          errors = 0;
    int          tests_run = 0;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #1.3;
        forever #7.5 lclk = ~lclk;
    end

    dbc_core DUT (.CLOCK_IN(clk), .RST_IN(rst), .REF_CLK_TRUE_IN(lclk), .CKE_IN(cke), .CS_N_IN(cs_n),
        .RAS_N_IN(cmd[2]), .CAS_N_IN(cmd[1]), .WE_N_IN(cmd[0]), .BA_IN(ba), .A_IN(a), .DQ_IN(dq_w),
        .DQS_IN(dqs_w), .DQ_OUT(d_dq), .DQ_OE_OUT(dq_oe), .DQS_OUT(d_dqs), .DQS_N_OUT(dqs_n), .DQS_OE_OUT(dqs_oe),
        .SELF_REFRESH_OUT(sref), .POWER_DOWN_OUT(pdn), .BANKS_OPEN_OUT(banks), .REFRESH_ROW_OUT(rrow));

    dbc_ctl_model u_ctl (.lclk_in(lclk), .dq_in(dq_w), .dqs_in(dqs_w), .dqs_n_in(dqs_n), .dq_oe_in(dq_oe),
        .dqs_oe_in(dqs_oe),
        .cke_out(cke), .cs_n_out(cs_n), .cmd_out(cmd), .ba_out(ba), .a_out(a), .dq_out(m_dq), .dqs_out(m_dqs));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic end_of_test();
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Beat i lands in nibble (c + i) mod 8
    function automatic logic [31:0] place(input logic [31:0] bt, input logic [2:0] c, input int n,
                                          input logic [31:0] old);
        for (int i = 0; i < n; i++) old[4*3'(c+i)+:4] = bt[4*i+:4];
        return old;
    endfunction

    function automatic logic [31:0] pick(input logic [31:0] w, input logic [2:0] c);
        logic [31:0] r;
        for (int i = 0; i < 8; i++) r[4*i+:4] = w[4*3'(c+i)+:4];
        return r;
    endfunction

    function automatic logic [13:0] ca(input logic bl, input logic ap, input logic [9:0] col);
        return {1'b0, bl, 1'b0, ap, col};
    endfunction

    // Whole run is some 5 us; cut a hang well past that
    initial begin
        #150000;
        errors++;
        end_of_test();
    end

    initial begin
        logic [31:0] wf, wk, e, rw;
        logic [9:0]  col;
        logic [2:0]  b, c2, c3;
        rst = 1'b1;
        void'($urandom(73301));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge lclk);
        for (int k = 0; k < 4; k++) begin
            b = 3'($urandom);
            col = (k == 0) ? 10'h3ff : 10'($urandom);
            c2 = 3'($urandom);
            c3 = (k == 0) ? 3'h7 : 3'($urandom);
            wf = $urandom;
            wk = $urandom;
            u_ctl.cmd(ACT, b, 14'($urandom), 1'b1);
            repeat (3) @(posedge lclk);
            chk(32'(banks[b]), 32'h1);
            u_ctl.cmd(WR, b, ca(1'b1, 1'b0, col), 1'b1);
            u_ctl.wr(wf, 8);
            u_ctl.cmd(WR, b, ca(1'b0, 1'b0, {col[9:3], c2}), 1'b1);
            u_ctl.wr(wk, 4);
            e = place(wk, c2, 4, place(wf, col[2:0], 8, 32'h0));
            u_ctl.cmd(RD, b, ca(1'b0, 1'b0, {col[9:3], c2}), 1'b1);
            u_ctl.rd(4, rw, ok);
            chk(rw, pick(e, c2) & 32'hffff);
            chk(32'(ok), 32'h1);
            u_ctl.cmd(RD, b, ca(1'b1, 1'b1, {col[9:3], c3}), 1'b1);
            u_ctl.rd(8, rw, ok);
            chk(rw, pick(e, c3));
            chk(32'(ok), 32'h1);
            repeat (3) @(posedge lclk);
            chk(32'(banks[b]), 32'h0);
        end
        // Two banks open together, then single and all-bank close
        u_ctl.cmd(ACT, 3'h2, 14'($urandom), 1'b1);
        u_ctl.cmd(ACT, 3'h5, 14'($urandom), 1'b1);
        repeat (3) @(posedge lclk);
        chk(32'(banks), 32'h24);
        u_ctl.cmd(PRE, 3'h2, 14'h0, 1'b1);
        repeat (3) @(posedge lclk);
        chk(32'(banks), 32'h20);
        u_ctl.cmd(PRE, 3'h0, 14'h0400, 1'b1);
        repeat (3) @(posedge lclk);
        chk(32'(banks), 32'h0);
        u_ctl.cmd(REF, 3'h0, 14'h0, 1'b0);
        repeat (20) @(posedge lclk);
        chk(32'(sref), 32'h1);
        chk(32'(rrow), 32'h1);
        u_ctl.cmd(NOP, 3'h0, 14'h0, 1'b1);
        repeat (6) @(posedge lclk);
        chk(32'(sref), 32'h0);
        u_ctl.cmd(NOP, 3'h0, 14'h0, 1'b0);
        repeat (6) @(posedge lclk);
        chk(32'(pdn), 32'h1);
        u_ctl.cmd(NOP, 3'h0, 14'h0, 1'b1);
        repeat (6) @(posedge lclk);
        chk(32'(pdn), 32'h0);
        end_of_test();
    end
endmodule // tb_top

`default_nettype wire
